// ==== src/fcd_defines.svh ====
// Register offsets, field positions and widths of the four-channel DMA controller.
// Included by the package and by every design file; holds definitions only.
`ifndef FCD_DEFINES_SVH
`define FCD_DEFINES_SVH
`define FCD_ADDR_W 8
`define FCD_DATA_W 32
`define FCD_CNT_W 16
`define FCD_OFF_W 5
`define FCD_CH_STRIDE_LOG2 5
`define FCD_GLOBAL_BIT 7
`define FCD_OFF_SRC 5'h00
`define FCD_OFF_DST 5'h04
`define FCD_OFF_CNT 5'h08
`define FCD_OFF_ADC 5'h0C
`define FCD_OFF_CTL 5'h10
`define FCD_OFF_TSEL 5'h14
`define FCD_OFF_STATUS 8'h80
`define FCD_OFF_MASK 8'h84
`define FCD_CTL_EN 0
`define FCD_CTL_DBL 1
`define FCD_CTL_SWT 2
`define FCD_CTL_PEND 3
`define FCD_CTL_BUSY 4
`define FCD_ADC_SRC_LSB 0
`define FCD_ADC_DST_LSB 2
`define FCD_ADC_SIZE_LSB 4
`define FCD_TSEL_W 3
`define FCD_TRIG_W 8
`define FCD_TRIG_NONE 0
`define FCD_TRIG_ADC 1
`define FCD_TRIG_PERIPH_LSB 2
`define FCD_TRIG_EXT_LSB 6
`endif

// ==== src/fcd_pkg.sv ====
// Types and the address step function shared by the DMA controller modules.
// Assumes fcd_defines.svh is on the include path.
`include "fcd_defines.svh"
package fcd_pkg;
  typedef enum logic [1:0] {FCD_IDLE = 2'h0, FCD_READ = 2'h1, FCD_WRITE = 2'h3} fcd_state_t;
  typedef enum logic [1:0] {FCD_AM_INC = 2'h0, FCD_AM_DEC = 2'h1, FCD_AM_FIX = 2'h2} fcd_amode_t;

  // Next address after one unit; a fixed address is how an I/O port is addressed.
  function automatic logic [`FCD_DATA_W-1:0] fcd_next_addr(input logic [`FCD_DATA_W-1:0] a,
                                                         input logic [1:0] mode, input logic [1:0] size);
    logic [`FCD_DATA_W-1:0] inc;
    inc = `FCD_DATA_W'(1) << size;
    case (mode)
      FCD_AM_INC: fcd_next_addr = a + inc;
      FCD_AM_DEC: fcd_next_addr = a - inc;
      default: fcd_next_addr = a;
    endcase
  endfunction
endpackage

// ==== src/fcd_chan_if.sv ====
// Carrier between the transfer engine and one channel's settings block.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
`default_nettype none
`include "fcd_defines.svh"
interface fcd_chan_if;
  logic wr;
  logic [`FCD_OFF_W-1:0] wsel;
  logic [`FCD_DATA_W-1:0] wdata;
  logic [`FCD_TRIG_W-1:0] trig_vec;
  logic grant;
  logic step;
  logic [`FCD_DATA_W-1:0] src;
  logic [`FCD_DATA_W-1:0] dst;
  logic [`FCD_CNT_W-1:0] cnt;
  logic [5:0] adc;
  logic en;
  logic dbl;
  logic pend;
  logic [`FCD_TSEL_W-1:0] tsel;
  logic req;
  logic done;
  modport core (output wr, wsel, wdata, trig_vec, grant, step,
                input src, dst, cnt, adc, en, dbl, pend, tsel, req, done);
  modport chan (input wr, wsel, wdata, trig_vec, grant, step,
                output src, dst, cnt, adc, en, dbl, pend, tsel, req, done);
endinterface
`default_nettype wire

// ==== src/fcd_chan.sv ====
// One DMA channel: its own settings, pending trigger and count bookkeeping.
// Assumes the engine raises step once per completed unit and grant when it takes a request.
`timescale 1ns/100ps
`default_nettype none
`include "fcd_defines.svh"
module fcd_chan
  import fcd_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst_b,
  fcd_chan_if.chan bus
);
  typedef struct packed {
    logic [`FCD_DATA_W-1:0] src;
    logic [`FCD_DATA_W-1:0] dst;
    logic [`FCD_CNT_W-1:0] cnt;
    logic [5:0] adc;
    logic en;
    logic dbl;
    logic pend;
    logic [`FCD_TSEL_W-1:0] tsel;
    logic trig_prev;
    logic done;
  } fcd_chan_state_t;

  fcd_chan_state_t q, d;
  logic trig_now;

  // Settings are private to this instance, so channels never disturb each other.
  always_comb begin
    d = q;
    d.done = 1'b0;
    trig_now = bus.trig_vec[q.tsel];
    d.trig_prev = trig_now;
    if (bus.grant) begin
      d.pend = 1'b0;
    end
    // Each finished unit moves the addresses and consumes one count.
    if (bus.step) begin
      d.src = fcd_next_addr(q.src, q.adc[`FCD_ADC_SRC_LSB +: 2], q.adc[`FCD_ADC_SIZE_LSB +: 2]);
      d.dst = fcd_next_addr(q.dst, q.adc[`FCD_ADC_DST_LSB +: 2], q.adc[`FCD_ADC_SIZE_LSB +: 2]);
      d.cnt = q.cnt - `FCD_CNT_W'(1);
      if (q.cnt == `FCD_CNT_W'(1)) begin
        d.en = 1'b0;
        d.pend = 1'b0;
        d.done = 1'b1;
      end
    end
    // Software writes come last so that they win over the engine's update.
    if (bus.wr) begin
      unique case (bus.wsel)
        `FCD_OFF_SRC: d.src = bus.wdata;
        `FCD_OFF_DST: d.dst = bus.wdata;
        `FCD_OFF_CNT: d.cnt = bus.wdata[`FCD_CNT_W-1:0];
        `FCD_OFF_ADC: d.adc = bus.wdata[5:0];
        `FCD_OFF_CTL: begin
          d.en = bus.wdata[`FCD_CTL_EN];
          d.dbl = bus.wdata[`FCD_CTL_DBL];
          if (!bus.wdata[`FCD_CTL_EN]) begin
            d.pend = 1'b0;
          end
        end
        `FCD_OFF_TSEL: d.tsel = bus.wdata[`FCD_TSEL_W-1:0];
        default: ;
      endcase
    end
    // A trigger edge or software trigger sets pending; the set beats a same-cycle grant.
    if (d.en && ((trig_now && !q.trig_prev && q.tsel != `FCD_TSEL_W'(`FCD_TRIG_NONE)) ||
                 (bus.wr && bus.wsel == `FCD_OFF_CTL && bus.wdata[`FCD_CTL_SWT]))) begin
      d.pend = 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign bus.src = q.src;
  assign bus.dst = q.dst;
  assign bus.cnt = q.cnt;
  assign bus.adc = q.adc;
  assign bus.en = q.en;
  assign bus.dbl = q.dbl;
  assign bus.pend = q.pend;
  assign bus.tsel = q.tsel;
  assign bus.done = q.done;
  // A channel with nothing left to move never asks for the bus.
  assign bus.req = q.pend && q.en && (q.cnt != '0);
endmodule
`default_nettype wire

// ==== src/fcd_top.sv ====
// Four-channel DMA controller: register port, trigger routing, fixed-priority engine
// and completion interrupt.
// Assumes a single 100 MHz clock, synchronous inputs and a memory bus that acknowledges
// each request with i_mem_ack, read data valid in the acknowledge cycle.
//
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "fcd_defines.svh"
// Summary of operation
// - Four independent channels, numbered zero to three, each run their own job.
// - A channel moves memory to I/O, memory to memory or I/O to I/O by per-side address modes.
// - A transfer is started by a peripheral request, an external interrupt pin or software.
// - Each channel keeps its own source, destination, count, addressing, control and trigger select.
// - Single mode moves one unit per trigger and double mode moves two when at least two remain.
// - Simultaneous requests are served by fixed priority, channel zero first and three last.
// - The converter's end-of-conversion interrupt can be chosen as a channel trigger.
module fcd_top
  import fcd_pkg::*;
#(
  parameter int NUM_CH = 4,
  parameter int NUM_PERIPH = 4,
  parameter int NUM_EXT = 2
) (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic [`FCD_ADDR_W-1:0] i_addr,
  input wire logic [`FCD_DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [`FCD_DATA_W-1:0] o_rdata,
  input wire logic [NUM_PERIPH-1:0] i_periph_req,
  input wire logic [NUM_EXT-1:0] i_ext_irq,
  input wire logic i_conversion_done_irq,
  output logic o_mem_req,
  output logic o_mem_we,
  output logic [`FCD_DATA_W-1:0] o_mem_addr,
  output logic [`FCD_DATA_W-1:0] o_mem_wdata,
  output logic [1:0] o_mem_size,
  input wire logic i_mem_ack,
  input wire logic [`FCD_DATA_W-1:0] i_mem_rdata,
  output logic o_busy,
  output logic [1:0] o_active_ch,
  output logic o_irq
);
  localparam int CHW = 2;

  typedef struct packed {
    fcd_state_t st;
    logic [CHW-1:0] ch;
    logic second;
    logic mem_req;
    logic mem_we;
    logic [`FCD_DATA_W-1:0] mem_addr;
    logic [`FCD_DATA_W-1:0] mem_wdata;
    logic [1:0] mem_size;
    logic [`FCD_DATA_W-1:0] rdata;
    logic [NUM_CH-1:0] status;
    logic [NUM_CH-1:0] mask;
    logic irq;
  } fcd_top_state_t;

  fcd_top_state_t q, d;

  // Per-channel views gathered from the channel blocks, and the grant, step and trigger lines driven into them.
  logic [NUM_CH-1:0] req_v;
  logic [NUM_CH-1:0] done_v;
  logic [NUM_CH-1:0] en_v;
  logic [NUM_CH-1:0] dbl_v;
  logic [NUM_CH-1:0] pend_v;
  logic [`FCD_DATA_W-1:0] src_a [NUM_CH];
  logic [`FCD_DATA_W-1:0] dst_a [NUM_CH];
  logic [`FCD_CNT_W-1:0] cnt_a [NUM_CH];
  logic [5:0] adc_a [NUM_CH];
  logic [`FCD_TSEL_W-1:0] tsel_a [NUM_CH];
  logic [NUM_CH-1:0] grant_v;
  logic [NUM_CH-1:0] step_v;
  logic [`FCD_TRIG_W-1:0] trig_vec;

  // Decoded register port.
  logic in_chan_space;
  logic [CHW-1:0] sel_ch;
  logic [`FCD_OFF_W-1:0] sel_off;

  assign in_chan_space = !i_addr[`FCD_GLOBAL_BIT];
  assign sel_ch = i_addr[`FCD_CH_STRIDE_LOG2 +: CHW];
  assign sel_off = i_addr[`FCD_OFF_W-1:0];

  // Trigger sources share one vector; code zero means software only.
  // The converter's completion interrupt has its own code so results drain to memory.
  always_comb begin
    trig_vec = '0;
    trig_vec[`FCD_TRIG_ADC] = i_conversion_done_irq;
    trig_vec[`FCD_TRIG_PERIPH_LSB +: NUM_PERIPH] = i_periph_req;
    trig_vec[`FCD_TRIG_EXT_LSB +: NUM_EXT] = i_ext_irq;
  end

  // One settings block per channel, each with its own interface.
  fcd_chan_if cif [NUM_CH] ();

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      fcd_chan u_chan (
        .i_clock(i_clock),
        .i_rst_b(i_rst_b),
        .bus(cif[g].chan)
      );
      // Writes reach only the channel that the address selects.
      assign cif[g].wr = i_wr && in_chan_space && (sel_ch == CHW'(g));
      assign cif[g].wsel = sel_off;
      assign cif[g].wdata = i_wdata;
      assign cif[g].trig_vec = trig_vec;
      assign cif[g].grant = grant_v[g];
      assign cif[g].step = step_v[g];
      assign req_v[g] = cif[g].req;
      assign done_v[g] = cif[g].done;
      assign en_v[g] = cif[g].en;
      assign dbl_v[g] = cif[g].dbl;
      assign pend_v[g] = cif[g].pend;
      assign src_a[g] = cif[g].src;
      assign dst_a[g] = cif[g].dst;
      assign cnt_a[g] = cif[g].cnt;
      assign adc_a[g] = cif[g].adc;
      assign tsel_a[g] = cif[g].tsel;
    end
  endgenerate

  // Engine, register reads and interrupt status, all in one next-state process.
  always_comb begin
    logic [CHW-1:0] pick;
    logic found;
    pick = '0;
    found = 1'b0;
    d = q;
    grant_v = '0;
    step_v = '0;

    // Fixed priority: scanning down leaves the lowest requesting number picked.
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (req_v[i]) begin
        pick = CHW'(i);
        found = 1'b1;
      end
    end

    // Read data stand for exactly the one cycle after the read strobe.
    d.rdata = '0;
    if (i_rd) begin
      if (in_chan_space) begin
        unique case (sel_off)
          `FCD_OFF_SRC: d.rdata = src_a[sel_ch];
          `FCD_OFF_DST: d.rdata = dst_a[sel_ch];
          `FCD_OFF_CNT: d.rdata = `FCD_DATA_W'(cnt_a[sel_ch]);
          `FCD_OFF_ADC: d.rdata = `FCD_DATA_W'(adc_a[sel_ch]);
          `FCD_OFF_CTL: begin
            d.rdata[`FCD_CTL_EN] = en_v[sel_ch];
            d.rdata[`FCD_CTL_DBL] = dbl_v[sel_ch];
            d.rdata[`FCD_CTL_PEND] = pend_v[sel_ch];
            d.rdata[`FCD_CTL_BUSY] = (q.st != FCD_IDLE) && (q.ch == sel_ch);
          end
          `FCD_OFF_TSEL: d.rdata = `FCD_DATA_W'(tsel_a[sel_ch]);
          default: d.rdata = '0;
        endcase
      end else if (i_addr == `FCD_OFF_STATUS) begin
        d.rdata = `FCD_DATA_W'(q.status);
      end else if (i_addr == `FCD_OFF_MASK) begin
        d.rdata = `FCD_DATA_W'(q.mask);
      end
    end

    // Completion bits are sticky and cleared by writing ones; a new completion in the
    // clearing cycle is kept, since the set is applied after the clear.
    if (i_wr && i_addr == `FCD_OFF_STATUS) begin
      d.status = q.status & ~i_wdata[NUM_CH-1:0];
    end
    d.status = d.status | done_v;
    if (i_wr && i_addr == `FCD_OFF_MASK) begin
      d.mask = i_wdata[NUM_CH-1:0];
    end
    d.irq = |(d.status & d.mask);

    // Transfer sequencer: each unit is one read followed by one write.
    unique case (q.st)
      FCD_IDLE: begin
        if (found) begin
          grant_v[pick] = 1'b1;
          d.ch = pick;
          // Double mode takes a second unit on the same trigger when count allows.
          d.second = dbl_v[pick] && (cnt_a[pick] > `FCD_CNT_W'(1));
          d.st = FCD_READ;
          d.mem_req = 1'b1;
          d.mem_we = 1'b0;
          d.mem_addr = src_a[pick];
          d.mem_size = adc_a[pick][`FCD_ADC_SIZE_LSB +: 2];
        end
      end
      FCD_READ: begin
        if (i_mem_ack) begin
          d.st = FCD_WRITE;
          d.mem_we = 1'b1;
          d.mem_addr = dst_a[q.ch];
          d.mem_wdata = i_mem_rdata;
        end
      end
      FCD_WRITE: begin
        if (i_mem_ack) begin
          step_v[q.ch] = 1'b1;
          if (q.second) begin
            // The channel's address update lands next cycle, so the step is computed here.
            d.second = 1'b0;
            d.st = FCD_READ;
            d.mem_we = 1'b0;
            d.mem_addr = fcd_next_addr(src_a[q.ch], adc_a[q.ch][`FCD_ADC_SRC_LSB +: 2],
                                       adc_a[q.ch][`FCD_ADC_SIZE_LSB +: 2]);
          end else begin
            d.st = FCD_IDLE;
            d.mem_req = 1'b0;
            d.mem_we = 1'b0;
          end
        end
      end
      default: begin
        d.st = FCD_IDLE;
        d.mem_req = 1'b0;
        d.mem_we = 1'b0;
      end
    endcase
  end

  // The engine, read data and interrupt state is one register; channel settings stay in the channel blocks.
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Every output comes straight from the state register.
  assign o_rdata = q.rdata;
  assign o_mem_req = q.mem_req;
  assign o_mem_we = q.mem_we;
  assign o_mem_addr = q.mem_addr;
  assign o_mem_wdata = q.mem_wdata;
  assign o_mem_size = q.mem_size;
  assign o_busy = (q.st != FCD_IDLE);
  assign o_active_ch = q.ch;
  assign o_irq = q.irq;
endmodule
`default_nettype wire

// ==== tb/fcd_top_sva.sv ====
// Checker for the DMA controller top: register reads, memory handshake and engine state.
// Assumes it is bound into fcd_top and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none
`include "fcd_defines.svh"
module fcd_top_sva (
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_rd,
  input wire logic [`FCD_DATA_W-1:0] o_rdata,
  input wire logic o_mem_req,
  input wire logic o_mem_we,
  input wire logic [`FCD_DATA_W-1:0] o_mem_addr,
  input wire logic [`FCD_DATA_W-1:0] o_mem_wdata,
  input wire logic i_mem_ack,
  input wire logic [`FCD_DATA_W-1:0] i_mem_rdata,
  input wire logic o_busy,
  input wire logic [1:0] o_active_ch,
  input wire logic o_irq
);
  // One clock domain, so clock and reset are given once for every property.
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  a_reset_quiet: assert property ($rose(i_rst_b) |-> !o_mem_req && !o_busy && !o_irq)
    else $error("engine active right after reset");
  a_rdata_idle: assert property (!$past(i_rd) |-> o_rdata == 32'h0000_0000)
    else $error("read data outside its cycle");
  a_req_hold: assert property (o_mem_req && !i_mem_ack |=> o_mem_req && $stable(o_mem_addr) && $stable(o_mem_we))
    else $error("memory request changed before acknowledge");
  a_write_data: assert property (o_mem_req && !o_mem_we && i_mem_ack |=> o_mem_req && o_mem_we && o_mem_wdata == $past(i_mem_rdata))
    else $error("write does not carry the data just read");
  a_write_end: assert property (o_mem_req && o_mem_we && i_mem_ack |=> !(o_mem_req && o_mem_we))
    else $error("write repeated after acknowledge");
  a_busy_req: assert property (o_mem_req |-> o_busy)
    else $error("memory request while engine idle");
  a_busy_bound: assert property (o_busy |-> ##[0:200] !o_busy)
    else $error("engine never returns to idle");
  a_group_chan: assert property (o_mem_req && $past(o_mem_req) |-> $stable(o_active_ch))
    else $error("channel changed inside a transfer");
  // Main scenarios: a stalled memory, a raised interrupt, the lowest priority channel served.
  c_stall: cover property (o_mem_req && !i_mem_ack);
  c_irq: cover property (o_irq);
  c_last_ch: cover property (o_mem_req && o_active_ch == 2'h3);
endmodule
bind fcd_top fcd_top_sva i_fcd_top_sva (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_mem_req(o_mem_req), .o_mem_we(o_mem_we), .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata),
  .i_mem_ack(i_mem_ack), .i_mem_rdata(i_mem_rdata), .o_busy(o_busy), .o_active_ch(o_active_ch), .o_irq(o_irq));
`default_nettype wire

// ==== tb/fcd_mem_model.sv ====
// Memory and I/O model on the far side of the DMA engine's memory port.
// Assumes the engine holds a request until acknowledged; reads return address xor a fixed key.
`timescale 1ns/100ps
`default_nettype none
module fcd_mem_model (
  input wire logic i_clock,
  input wire logic i_slow,
  input wire logic i_mem_req,
  input wire logic i_mem_we,
  input wire logic [31:0] i_mem_addr,
  input wire logic [31:0] i_mem_wdata,
  output logic o_mem_ack,
  output logic [31:0] o_mem_rdata,
  output logic [31:0] o_wr_n,
  output logic [31:0] o_wr_addr,
  output logic [31:0] o_wr_data
);
  logic [1:0] wait_q = 2'h0;
  initial o_wr_n = 32'h0000_0000;
  // Slow mode stalls two cycles; outside the acknowledge the data lines carry garbage on purpose.
  assign o_mem_ack = i_mem_req && (wait_q == 2'h0);
  assign o_mem_rdata = o_mem_ack ? (i_mem_addr ^ 32'h5A5A_0000) : ~(i_mem_addr ^ 32'h5A5A_0000);
  // Count down while stalled and record every accepted write.
  always @(posedge i_clock) begin
    wait_q <= (i_mem_req && !o_mem_ack) ? wait_q - 2'h1 : (i_slow ? 2'h2 : 2'h0);
    if (o_mem_ack && i_mem_we) begin
      o_wr_n <= o_wr_n + 32'h1;
      o_wr_addr <= i_mem_addr;
      o_wr_data <= i_mem_wdata;
    end
  end
endmodule
`default_nettype wire

// ==== tb/fcd_top_test.sv ====
// Self-checking bench for the DMA controller: register tasks, triggers and memory model.
// Assumes the design sources and the memory model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module fcd_top_test;
  localparam logic [31:0] KEY = 32'h5A5A_0000;
  logic i_clock = 1'b0;
  logic i_rst_b = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0000_0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [6:0] trg = 7'h00;
  logic slow = 1'b0;
  logic [31:0] rdata, maddr, mwdata, mrdata, wr_n, waddr, wdata, n0;
  logic mreq, mwe, mack, busy, irq;
  logic [1:0] msize, act, wsize;
  logic [1:0] order[$];
  int n_fail = 0;
  int checks = 0;
  // Trigger inputs share one vector: bit t-1 belongs to trigger select value t.
  fcd_top i_fcd_top (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(rdata), .i_periph_req(trg[4:1]), .i_ext_irq(trg[6:5]), .i_conversion_done_irq(trg[0]),
    .o_mem_req(mreq), .o_mem_we(mwe), .o_mem_addr(maddr), .o_mem_wdata(mwdata), .o_mem_size(msize),
    .i_mem_ack(mack), .i_mem_rdata(mrdata), .o_busy(busy), .o_active_ch(act), .o_irq(irq));
  fcd_mem_model i_fcd_mem_model (.i_clock(i_clock), .i_slow(slow), .i_mem_req(mreq), .i_mem_we(mwe),
    .i_mem_addr(maddr), .i_mem_wdata(mwdata), .o_mem_ack(mack), .o_mem_rdata(mrdata), .o_wr_n(wr_n),
    .o_wr_addr(waddr), .o_wr_data(wdata));
  // Clock of 10 ns period.
  always #5 i_clock = ~i_clock;
  // Record which channel starts each unit, to see the service order.
  always @(posedge i_clock) begin
    if (mreq && !mwe && mack) order.push_back(act);
    // The unit size is kept from the last accepted write so that it can be compared later.
    if (mreq && mwe && mack) wsize <= msize;
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask
  // Read data stands only in the cycle after the strobe, so it is sampled there.
  task automatic rd(input logic [7:0] a, input string nm, input logic [31:0] exp);
    @(posedge i_clock);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1;
    chk(nm, exp, rdata);
  endtask
  task automatic setup(input int ch, input logic [31:0] s, input logic [31:0] d, input logic [31:0] n,
                       input logic [31:0] am, input logic [31:0] ts, input logic [31:0] ctl);
    wr(8'(ch * 32), s);
    wr(8'(ch * 32 + 4), d);
    wr(8'(ch * 32 + 8), n);
    wr(8'(ch * 32 + 12), am);
    wr(8'(ch * 32 + 20), ts);
    wr(8'(ch * 32 + 16), ctl);
  endtask
  task automatic pulse(input logic [6:0] b);
    @(posedge i_clock);
    trg <= b;
    @(posedge i_clock);
    trg <= 7'h00;
  endtask
  // Wait, bounded, for six quiet cycles in a row; a short dip between channels does not end it.
  task automatic idle();
    int n;
    n = 0;
    for (int k = 0; k < 400 && n < 6; k++) begin
      @(posedge i_clock);
      n = busy ? 0 : n + 1;
    end
    chk("engine idle", 32'h1, {31'h0, n == 6});
  endtask
  task automatic test_done();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #300000;
    n_fail++;
    test_done();
  end
  initial begin
    repeat (10) @(posedge i_clock);
    i_rst_b <= 1'b1;
    for (int c = 0; c < 4; c++) wr(8'(c * 32), 32'h1000_0000 + c);
    for (int c = 0; c < 4; c++) rd(8'(c * 32), "source address", 32'h1000_0000 + c);
    rd(8'h18, "unmapped", 32'h0);
    $display("test registers done");
    wr(8'h84, 32'h1);
    setup(0, 32'h1000, 32'h2000, 1, 32'h10, 0, 5);
    idle();
    chk("write address", 32'h2000, waddr);
    chk("write data", 32'h1000 ^ KEY, wdata);
    chk("unit size", 32'h1, {30'h0, wsize});
    rd(8'h08, "count", 32'h0);
    rd(8'h10, "control", 32'h0);
    rd(8'h80, "status", 32'h1);
    chk("irq", 32'h1, {31'h0, irq});
    wr(8'h80, 32'h1);
    repeat (2) @(posedge i_clock);
    #1;
    chk("irq cleared", 32'h0, {31'h0, irq});
    $display("test software single done");
    wr(8'h80, 32'hF);
    setup(3, 32'h3300, 32'h3400, 1, 32'h20, 2, 1);
    setup(1, 32'h1100, 32'h1200, 1, 32'h20, 2, 1);
    setup(2, 32'h2100, 32'h2200, 1, 32'h20, 2, 0);
    order.delete();
    pulse(7'h02);
    idle();
    chk("served channels", 32'h2, order.size());
    chk("first channel", 32'h1, {30'h0, order[0]});
    chk("second channel", 32'h3, {30'h0, order[1]});
    $display("test priority done");
    slow <= 1'b1;
    n0 = wr_n;
    setup(2, 32'h3000, 32'h4000, 3, 32'h24, 0, 7);
    idle();
    rd(8'h48, "double count", 32'h1);
    chk("double units", n0 + 2, wr_n);
    chk("double address", 32'h3FFC, waddr);
    chk("double size", 32'h2, {30'h0, wsize});
    chk("double data", 32'h3004 ^ KEY, wdata);
    slow <= 1'b0;
    $display("test double slow done");
    for (int t = 1; t < 8; t++) begin
      setup(0, 32'h0100 + t, 32'h0200, 1, 32'h22, t, 1);
      n0 = wr_n;
      pulse(~(7'h01 << (t - 1)));
      idle();
      chk("other triggers", n0, wr_n);
      pulse(7'h01 << (t - 1));
      idle();
      chk("selected trigger", n0 + 1, wr_n);
      chk("fixed source data", (32'h0100 + t) ^ KEY, wdata);
    end
    $display("test trigger select done");
    test_done();
  end
endmodule
`default_nettype wire
